// ---- verilog/rcc_pkg.sv ----
// Purpose: Constants for the receive path, quadrature clock, guard delay and CRC/parity block.
// Assumes: 32-bit classic Wishbone, byte address = 4 * register index.
// Notes:   Registers hold 8 bits in the low lane; upper bits read as zero.
package rcc_pkg;
   localparam logic [7:0] IDX_RX_CTRL    = 8'h1E;
   localparam logic [7:0] IDX_QCLK_CTRL  = 8'h1F;
   localparam logic [7:0] IDX_GUARD      = 8'h21;
   localparam logic [7:0] IDX_CHAN       = 8'h22;
   localparam logic [7:0] IDX_PRESET_LO  = 8'h23;
   localparam logic [7:0] IDX_PRESET_HI  = 8'h24;
   localparam logic [7:0] IDX_STATUS     = 8'h30;
   localparam logic [7:0] RST_RX_CTRL    = 8'h41;
   localparam logic [7:0] RST_GUARD      = 8'h06;
   localparam logic [7:0] RST_CHAN       = 8'h03;
   localparam logic [7:0] RST_PRESET     = 8'h63;
   localparam logic [7:0] RX_CTRL_WMASK  = 8'hC3;
   localparam logic [7:0] CHAN_WMASK     = 8'h3F;
   localparam int RX_CLK_SEL_BIT  = 7;
   localparam int RX_AUTO_PD_BIT  = 6;
   localparam int QCLK_HALF_BIT   = 7;
   localparam int QCLK_CALDIS_BIT = 6;
   localparam int QCLK_RES_BIT    = 5;
   localparam int CH_VAR_B_BIT    = 5;
   localparam int CH_SHORT_BIT    = 4;
   localparam int CH_RXCRC_BIT    = 3;
   localparam int CH_TXCRC_BIT    = 2;
   localparam int CH_ODD_BIT      = 1;
   localparam int CH_PAR_BIT      = 0;
   localparam int ST_CRC_ERR_BIT  = 0;
   localparam int ST_PAR_ERR_BIT  = 1;
   localparam logic [1:0] DEC_LOW   = 2'h0;
   localparam logic [1:0] DEC_DEMOD = 2'h1;
   localparam logic [1:0] DEC_SUBC  = 2'h2;
   localparam logic [15:0] CRC16_POLY_REFL = 16'h8408;
   localparam logic [7:0]  SHORT_CRC_SELECT_POLY_REFL  = 8'hE0;
   localparam logic [15:0] CRC_B_RESIDUE   = 16'hF0B8;
   localparam logic [4:0]  QDELAY_MAX      = 5'h1F;
   typedef enum logic [1:0] {CAL_IDLE = 2'b00, CAL_RUN = 2'b01} rcc_cal_t;
endpackage

// ---- verilog/rcc_core.sv ----
// Purpose: Register bank and datapath for receive configuration and channel integrity.
// Assumes: All strobes are one-cycle pulses synchronous to clk_sys.
// Notes:   The CRC residue is checked at rx_end, after the last byte was taken.
module rcc_core (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tx_start,
   input  wire logic        tx_end,
   input  wire logic        rx_start,
   input  wire logic        rx_end,
   input  wire logic        compute_crc_command,
   input  wire logic        bit_clk_tick,
   input  wire logic        rx_pin,
   input  wire logic        demod_in,
   input  wire logic        aux_serial_input,
   input  wire logic        quad_phase_over_half,
   input  wire logic        quad_phase_reached,
   input  wire logic        tx_byte_valid,
   input  wire logic [7:0]  tx_byte,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_parity_in,
   output logic             receiver_clock_select,
   output logic             receiver_power_on,
   output logic             receive_window_open,
   output logic             rx_pin_gated,
   output logic             decoder_data,
   output logic             decoder_aux_subcarrier,
   output logic      [4:0]  quad_clock_delay_count,
   output logic             calib_busy,
   output logic             tx_parity_insert,
   output logic             tx_parity_bit,
   output logic             tx_crc_append,
   output logic      [15:0] crc_result,
   output logic             fifo_wr_valid,
   output logic      [7:0]  fifo_wr_data,
   output logic             crc_error_flag,
   output logic             parity_error_flag
);
   // ==========================================================
   // State
   typedef struct packed {
      logic            ack;
      logic [7:0]      rdata;
      logic [7:0]      rx_ctrl;
      logic            q_res;
      logic [4:0]      qdelay;
      logic [7:0]      guard;
      logic [7:0]      chan;
      logic [7:0]      pre_lo;
      logic [7:0]      pre_hi;
      logic [15:0]     crc;
      logic            crc_err;
      logic            par_err;
      logic [7:0]      guard_cnt;
      logic            guard_busy;
      logic            rx_active;
      rcc_pkg::rcc_cal_t cal;
      logic            cal_dis;
      logic [7:0]      h0;
      logic [7:0]      h1;
      logic [1:0]      hcnt;
      logic            flush;
      logic            fwr;
      logic [7:0]      fdata;
      logic            tpar;
   } rcc_state_t;

   rcc_state_t st_reg;
   rcc_state_t st_next;

   // ==========================================================
   // Functions
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                            input logic short_crc);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         if (short_crc) begin
            r = {8'h00, (r[7:0] >> 1) ^ (r[0] ? rcc_pkg::SHORT_CRC_SELECT_POLY_REFL : 8'h00)};
         end else begin
            r = (r >> 1) ^ (r[0] ? rcc_pkg::CRC16_POLY_REFL : 16'h0000);
         end
      end
      return r;
   endfunction

   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction

   // ==========================================================
   // Decode and combinational outputs
   logic        acc;
   logic        wr;
   logic [7:0]  idx;
   logic [7:0]  wd;
   logic        var_b;
   logic        short_crc;
   logic        n2;
   logic [15:0] residue;
   logic        crc_bad;
   logic        caldis_q;

   assign acc       = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign wr        = acc && wb_we_i && wb_sel_i[0];
   assign idx       = {2'b00, wb_adr_i[7:2]};
   assign wd        = wb_dat_i[7:0];
   assign var_b     = st_reg.chan[rcc_pkg::CH_VAR_B_BIT];
   assign short_crc = st_reg.chan[rcc_pkg::CH_SHORT_BIT];
   assign n2        = !short_crc;
   assign residue   = (var_b && !short_crc) ? rcc_pkg::CRC_B_RESIDUE : 16'h0000;
   assign crc_bad   = short_crc ? (st_reg.crc[7:0] != residue[7:0]) : (st_reg.crc != residue);
   assign caldis_q  = st_reg.cal_dis;

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = {24'h000000, st_reg.rdata};
   assign receiver_clock_select = st_reg.rx_ctrl[rcc_pkg::RX_CLK_SEL_BIT];
   assign receiver_power_on = !st_reg.rx_ctrl[rcc_pkg::RX_AUTO_PD_BIT] || st_reg.rx_active;
   assign receive_window_open = !st_reg.guard_busy;
   assign rx_pin_gated = rx_pin && !st_reg.guard_busy;
   assign quad_clock_delay_count = st_reg.qdelay;
   assign calib_busy = (st_reg.cal == rcc_pkg::CAL_RUN);
   assign tx_parity_insert = st_reg.chan[rcc_pkg::CH_PAR_BIT];
   assign tx_parity_bit = st_reg.tpar;
   assign tx_crc_append = st_reg.chan[rcc_pkg::CH_TXCRC_BIT];
   assign crc_result = short_crc ? {8'h00, st_reg.crc[7:0]} : (var_b ? ~st_reg.crc : st_reg.crc);
   assign fifo_wr_valid = st_reg.fwr;
   assign fifo_wr_data = st_reg.fdata;
   assign crc_error_flag = st_reg.crc_err;
   assign parity_error_flag = st_reg.par_err;

   always_comb begin
      decoder_aux_subcarrier = 1'b0;
      case (st_reg.rx_ctrl[1:0])
         rcc_pkg::DEC_LOW: begin
            decoder_data = 1'b0;
         end
         rcc_pkg::DEC_DEMOD: begin
            decoder_data = demod_in;
         end
         rcc_pkg::DEC_SUBC: begin
            decoder_data = aux_serial_input;
            decoder_aux_subcarrier = 1'b1;
         end
         default: begin
            decoder_data = aux_serial_input;
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.ack = acc;
      st_next.fwr = 1'b0;
      st_next.rdata = 8'h00;
      if (acc && !wb_we_i) begin
         case (idx)
            rcc_pkg::IDX_RX_CTRL: st_next.rdata = st_reg.rx_ctrl;
            rcc_pkg::IDX_QCLK_CTRL: st_next.rdata = {quad_phase_over_half, caldis_q,
               st_reg.q_res, st_reg.qdelay};
            rcc_pkg::IDX_GUARD: st_next.rdata = st_reg.guard;
            rcc_pkg::IDX_CHAN: st_next.rdata = st_reg.chan;
            rcc_pkg::IDX_PRESET_LO: st_next.rdata = st_reg.pre_lo;
            rcc_pkg::IDX_PRESET_HI: st_next.rdata = st_reg.pre_hi;
            rcc_pkg::IDX_STATUS: st_next.rdata = {6'h00, st_reg.par_err, st_reg.crc_err};
            default: st_next.rdata = 8'h00;
         endcase
      end
      case (st_reg.cal)
         rcc_pkg::CAL_RUN: begin
            if (quad_phase_reached || st_reg.qdelay == rcc_pkg::QDELAY_MAX) begin
               st_next.cal = rcc_pkg::CAL_IDLE;
            end else begin
               st_next.qdelay = st_reg.qdelay + 5'h01;
            end
         end
         default: begin
            if (rx_end && !caldis_q) begin
               st_next.cal = rcc_pkg::CAL_RUN;
               st_next.qdelay = 5'h00;
            end
         end
      endcase
      if (wr) begin
         case (idx)
            rcc_pkg::IDX_RX_CTRL: st_next.rx_ctrl = wd & rcc_pkg::RX_CTRL_WMASK;
            rcc_pkg::IDX_QCLK_CTRL: begin
               st_next.q_res = wd[rcc_pkg::QCLK_RES_BIT];
               st_next.cal_dis = wd[rcc_pkg::QCLK_CALDIS_BIT];
               st_next.qdelay = wd[4:0];
               st_next.cal = rcc_pkg::CAL_IDLE;
            end
            rcc_pkg::IDX_GUARD: st_next.guard = wd;
            rcc_pkg::IDX_CHAN: st_next.chan = wd & rcc_pkg::CHAN_WMASK;
            rcc_pkg::IDX_PRESET_LO: st_next.pre_lo = wd;
            rcc_pkg::IDX_PRESET_HI: st_next.pre_hi = wd;
            rcc_pkg::IDX_STATUS: begin
               if (wd[rcc_pkg::ST_CRC_ERR_BIT]) st_next.crc_err = 1'b0;
               if (wd[rcc_pkg::ST_PAR_ERR_BIT]) st_next.par_err = 1'b0;
            end
            default: st_next.guard = st_reg.guard;
         endcase
      end
      if (tx_end) begin
         st_next.guard_cnt = st_reg.guard;
         st_next.guard_busy = (st_reg.guard != 8'h00);
         st_next.rx_active = (st_reg.guard == 8'h00);
      end else if (st_reg.guard_busy && bit_clk_tick) begin
         st_next.guard_cnt = st_reg.guard_cnt - 8'h01;
         if (st_reg.guard_cnt == 8'h01) begin
            st_next.guard_busy = 1'b0;
            st_next.rx_active = 1'b1;
         end
      end
      if (rx_start) st_next.rx_active = 1'b1;
      if (rx_end) st_next.rx_active = 1'b0;
      if ((tx_start && st_reg.chan[rcc_pkg::CH_TXCRC_BIT]) ||
          (rx_start && st_reg.chan[rcc_pkg::CH_RXCRC_BIT]) || compute_crc_command) begin
         st_next.crc = {st_reg.pre_hi, st_reg.pre_lo};
      end else if (tx_byte_valid) begin
         st_next.crc = crc_step(st_reg.crc, tx_byte, short_crc);
      end else if (rx_byte_valid) begin
         st_next.crc = crc_step(st_reg.crc, rx_byte, short_crc);
      end
      if (tx_byte_valid) st_next.tpar = parity_of(tx_byte, st_reg.chan[rcc_pkg::CH_ODD_BIT]);
      if (rx_byte_valid && st_reg.chan[rcc_pkg::CH_PAR_BIT] &&
          rx_parity_in != parity_of(rx_byte, st_reg.chan[rcc_pkg::CH_ODD_BIT])) begin
         st_next.par_err = 1'b1;
      end
      if (st_reg.flush) begin
         if (st_reg.hcnt != 2'h0) begin
            st_next.fwr = 1'b1;
            st_next.fdata = st_reg.h0;
            st_next.h0 = st_reg.h1;
            st_next.hcnt = st_reg.hcnt - 2'h1;
         end else begin
            st_next.flush = 1'b0;
         end
      end else if (rx_byte_valid && !st_reg.chan[rcc_pkg::CH_RXCRC_BIT]) begin
         st_next.fwr = 1'b1;
         st_next.fdata = rx_byte;
      end else if (rx_byte_valid) begin
         if (st_reg.hcnt == {n2, !n2}) begin
            st_next.fwr = 1'b1;
            st_next.fdata = st_reg.h0;
            st_next.h0 = n2 ? st_reg.h1 : rx_byte;
            st_next.h1 = rx_byte;
         end else begin
            if (st_reg.hcnt == 2'h0) st_next.h0 = rx_byte;
            else st_next.h1 = rx_byte;
            st_next.hcnt = st_reg.hcnt + 2'h1;
         end
      end else if (rx_end && st_reg.chan[rcc_pkg::CH_RXCRC_BIT]) begin
         if (crc_bad) begin
            st_next.crc_err = 1'b1;
            st_next.flush = 1'b1;
         end else begin
            st_next.hcnt = 2'h0;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.rx_ctrl <= rcc_pkg::RST_RX_CTRL;
         st_reg.guard <= rcc_pkg::RST_GUARD;
         st_reg.chan <= rcc_pkg::RST_CHAN;
         st_reg.pre_lo <= rcc_pkg::RST_PRESET;
         st_reg.pre_hi <= rcc_pkg::RST_PRESET;
         st_reg.cal <= rcc_pkg::CAL_RUN;
         st_reg.rx_active <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Checks
   chk_clock_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr && idx == rcc_pkg::IDX_RX_CTRL
      |=> receiver_clock_select == $past(wd[rcc_pkg::RX_CLK_SEL_BIT]))
      else $error("clock select mismatch");
   chk_power_always: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_reg.rx_ctrl[6] |-> receiver_power_on) else $error("receiver powered off");
   chk_decoder_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.rx_ctrl[1:0] == 2'h0 |-> !decoder_data) else $error("decoder not low");
   chk_guard_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.guard_busy |-> !rx_pin_gated) else $error("rx pin seen in guard");
   chk_guard_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      tx_end |=> st_reg.guard_cnt == $past(st_reg.guard)) else $error("guard not reloaded");
   chk_guard_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.guard_busy && st_reg.guard_cnt == 8'h01 && bit_clk_tick && !tx_end
      |=> !st_reg.guard_busy)
      else $error("guard not ended");
   chk_preset_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      compute_crc_command |=> st_reg.crc == {$past(st_reg.pre_hi), $past(st_reg.pre_lo)})
      else $error("preset not loaded");
   chk_parity_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_byte_valid && st_reg.chan[0] && rx_parity_in != parity_of(rx_byte, st_reg.chan[1])
      |=> parity_error_flag) else $error("parity error missed");
   chk_crc_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_end && !rx_byte_valid && !st_reg.flush && st_reg.chan[3] && crc_bad
      |=> crc_error_flag) else $error("crc error missed");
   chk_calib_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_reg.cal == rcc_pkg::CAL_IDLE && rx_end && st_reg.cal_dis |=> !calib_busy)
      else $error("calibration while disabled");
endmodule

// ---- testbench/rcc_host_model.sv ----
// Purpose: Host processor model that reaches the register bank over classic Wishbone.
// Assumes: The slave answers each request with a registered acknowledge.
// Notes:   Released write data is inverted so a stale value never looks fresh.
module rcc_host_model (
   input  wire logic        clk_sys,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic      [7:0]  adr,
   output logic      [3:0]  sel,
   output logic      [31:0] dat
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {cyc, stb, we, adr, sel, dat} = '0;
   end

   // ==========
   // Bus cycle
   task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                         output logic [7:0] rd);
      logic [7:0] d;
      d = wd;
      if (idx == rcc_pkg::IDX_RX_CTRL) d = wd & rcc_pkg::RX_CTRL_WMASK;
      if (idx == rcc_pkg::IDX_CHAN) d = wd & rcc_pkg::CHAN_WMASK;
      if (idx == rcc_pkg::IDX_QCLK_CTRL) d[5] = 1'b0;
      if (idx == rcc_pkg::IDX_CHAN && !d[5] && d[0]) d[1] = 1'b1;
      @(posedge clk_sys);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, idx[5:0], 2'b00, 4'h1, 24'h0, d};
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      {cyc, stb, we} <= 3'b000;
      dat <= ~dat;
      @(posedge clk_sys);
   endtask
endmodule

// ---- testbench/rx_config_crc_parity_tb_top.sv ----
// Purpose: Self-checking bench for the receive configuration and channel integrity bank.
// Assumes: The analog side reports the calibration target at a fixed delay count.
// Notes:   Event inputs are one-cycle pulses; each event task lets two edges pass.
module rx_config_crc_parity_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] CAL_TARGET = 5'h0A;
   logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_pin, demod_in;
   logic        aux_serial_input, quad_phase_over_half, tx_byte_valid, rx_byte_valid;
   logic        rx_parity_in, receiver_clock_select, receiver_power_on, receive_window_open;
   logic        rx_pin_gated, decoder_data, decoder_aux_subcarrier, calib_busy;
   logic        tx_parity_insert, tx_parity_bit, tx_crc_append, fifo_wr_valid;
   logic        crc_error_flag, parity_error_flag;
   logic [3:0]  wb_sel_i;
   logic [4:0]  quad_clock_delay_count;
   logic [5:0]  evs;
   logic [7:0]  wb_adr_i, tx_byte, rx_byte, fifo_wr_data, rd, flast;
   logic [15:0] crc_result;
   logic [31:0] wb_dat_i, wb_dat_o;
   wire logic   quad_phase_reached;
   int          miscompares, checks, fcnt;

   assign quad_phase_reached = (quad_clock_delay_count == CAL_TARGET);

   rcc_core i_rcc_core (
      .clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .tx_start(evs[0]), .tx_end(evs[1]), .rx_start(evs[2]),
      .rx_end(evs[3]), .compute_crc_command(evs[4]), .bit_clk_tick(evs[5]), .rx_pin,
      .demod_in, .aux_serial_input, .quad_phase_over_half, .quad_phase_reached,
      .tx_byte_valid, .tx_byte, .rx_byte_valid, .rx_byte, .rx_parity_in,
      .receiver_clock_select, .receiver_power_on, .receive_window_open, .rx_pin_gated,
      .decoder_data, .decoder_aux_subcarrier, .quad_clock_delay_count, .calib_busy,
      .tx_parity_insert, .tx_parity_bit, .tx_crc_append, .crc_result, .fifo_wr_valid,
      .fifo_wr_data, .crc_error_flag, .parity_error_flag);
   rcc_host_model i_rcc_host_model (
      .clk_sys, .ack(wb_ack_o), .rdat(wb_dat_o), .cyc(wb_cyc_i), .stb(wb_stb_i),
      .we(wb_we_i), .adr(wb_adr_i), .sel(wb_sel_i), .dat(wb_dat_i));

   // ==========
   // Helpers
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      i_rcc_host_model.access(1'b1, idx, d, rd);
   endtask
   task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
      i_rcc_host_model.access(1'b0, idx, 8'h00, rd);
      chk(what, {8'h00, rd}, {8'h00, exp});
   endtask
   task automatic ev(input int k);
      evs <= 6'h01 << k;
      @(posedge clk_sys);
      evs <= 6'h00;
      @(posedge clk_sys);
   endtask
   task automatic xb(input logic rx, input logic [7:0] b, input logic p);
      {tx_byte, rx_byte, rx_parity_in, tx_byte_valid, rx_byte_valid} <= {b, b, p, !rx, rx};
      @(posedge clk_sys);
      {tx_byte_valid, rx_byte_valid} <= 2'b00;
      @(posedge clk_sys);
   endtask
   task automatic wait_cal();
      for (int n = 0; n < 100 && calib_busy !== 1'b0; n++) @(posedge clk_sys);
   endtask
   function automatic logic par(input logic [7:0] b, input logic odd);
      return (^b) ^ odd;
   endfunction
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                            input logic s8);
      for (int i = 0; i < 8; i++) begin
         if (s8) begin
            c[7:0] = (c[0] ^ d[i]) ? (c[7:0] >> 1) ^ rcc_pkg::SHORT_CRC_SELECT_POLY_REFL : c[7:0] >> 1;
         end else begin
            c = (c[0] ^ d[i]) ? (c >> 1) ^ rcc_pkg::CRC16_POLY_REFL : c >> 1;
         end
      end
      return c;
   endfunction
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========
   // Clock, capture and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (fifo_wr_valid === 1'b1) begin
         fcnt <= fcnt + 1;
         flast <= fifo_wr_data;
      end
   end
   initial begin
      #100us;
      miscompares++;
      close_out();
   end

   // ==========
   // Tests
   initial begin
      logic [7:0]  cv, b2;
      logic [15:0] c;
      logic        s8, odd;
      {rst_n, evs, tx_byte_valid, rx_byte_valid, tx_byte, rx_byte, rx_parity_in} = '0;
      {rx_pin, demod_in, aux_serial_input, quad_phase_over_half, flast} = '1;
      {miscompares, checks, fcnt} = '0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_cal();
      chk("calib_delay", quad_clock_delay_count, CAL_TARGET);
      rdc("rx_ctrl_rst", rcc_pkg::IDX_RX_CTRL, 8'h41);
      rdc("guard_rst", rcc_pkg::IDX_GUARD, 8'h06);
      rdc("chan_rst", rcc_pkg::IDX_CHAN, 8'h03);
      rdc("preset_lo_rst", rcc_pkg::IDX_PRESET_LO, 8'h63);
      rdc("preset_hi_rst", rcc_pkg::IDX_PRESET_HI, 8'h63);
      rdc("qclk_rd", rcc_pkg::IDX_QCLK_CTRL, 8'h8A);
      wr(8'h10, 8'hA5);
      rdc("unmapped", 8'h10, 8'h00);
      $display("test registers done");
      wr(rcc_pkg::IDX_QCLK_CTRL, 8'h03);
      chk("pd_idle", receiver_power_on, 1'b0);
      ev(2);
      chk("pd_rx", receiver_power_on, 1'b1);
      ev(3);
      chk("pd_after", receiver_power_on, 1'b0);
      chk("recal_start", calib_busy, 1'b1);
      wait_cal();
      chk("recal_delay", quad_clock_delay_count, CAL_TARGET);
      quad_phase_over_half <= 1'b0;
      wr(rcc_pkg::IDX_QCLK_CTRL, 8'h45);
      rdc("qclk_wr", rcc_pkg::IDX_QCLK_CTRL, 8'h45);
      ev(2);
      ev(3);
      chk("no_recal", {calib_busy, 3'h0, quad_clock_delay_count}, 9'h005);
      $display("test power_calibration done");
      for (int k = 0; k < 8; k++) begin
         cv = {k[2], 5'h00, k[1:0]};
         wr(rcc_pkg::IDX_RX_CTRL, cv);
         rdc("rx_ctrl_rw", rcc_pkg::IDX_RX_CTRL, cv);
         chk("clk_sel", receiver_clock_select, k[2]);
         chk("pd_off", receiver_power_on, 1'b1);
         chk("aux_subc", decoder_aux_subcarrier, k[1:0] == 2'h2);
         for (int v = 0; v < 2; v++) begin
            {demod_in, aux_serial_input} <= {v[0], !v[0]};
            @(posedge clk_sys);
            @(posedge clk_sys);
            chk("dec_data", decoder_data, (k[1:0] == 2'h0) ? 1'b0 : (k[1] ? !v[0] : v[0]));
         end
      end
      $display("test decoder done");
      wr(rcc_pkg::IDX_GUARD, 8'h03);
      ev(1);
      chk("guard_closed", {receive_window_open, rx_pin_gated}, 2'h0);
      ev(5);
      ev(5);
      ev(1);
      ev(5);
      ev(5);
      chk("guard_restart", {receive_window_open, rx_pin_gated}, 2'h0);
      ev(5);
      chk("guard_open", {receive_window_open, rx_pin_gated}, 2'h3);
      wr(rcc_pkg::IDX_GUARD, 8'h00);
      ev(1);
      chk("guard_zero", {receive_window_open, rx_pin_gated}, 2'h3);
      $display("test guard done");
      for (int m = 0; m < 3; m++) begin
         cv = (m == 0) ? 8'h0F : ((m == 1) ? 8'h2D : 8'h1F);
         s8 = cv[4];
         odd = cv[1];
         wr(rcc_pkg::IDX_CHAN, cv);
         rdc("chan_rw", rcc_pkg::IDX_CHAN, cv);
         chk("tx_flags", {tx_crc_append, tx_parity_insert}, 2'h3);
         ev(0);
         xb(1'b0, 8'h12, 1'b0);
         xb(1'b0, 8'h34, 1'b0);
         c = crc_step(crc_step(s8 ? 16'h0063 : 16'h6363, 8'h12, s8), 8'h34, s8);
         if (cv[5]) c = ~c;
         chk("crc_tx", crc_result & (s8 ? 16'h00FF : 16'hFFFF), s8 ? {8'h00, c[7:0]} : c);
         chk("tx_parity", tx_parity_bit, par(8'h34, odd));
         for (int bad = 0; bad < 2; bad++) begin
            fcnt = 0;
            ev(2);
            xb(1'b1, 8'h12, par(8'h12, odd));
            xb(1'b1, 8'h34, par(8'h34, odd));
            b2 = c[7:0] ^ bad[7:0];
            xb(1'b1, b2, par(b2, odd));
            if (!s8) xb(1'b1, c[15:8], par(c[15:8], odd));
            ev(3);
            repeat (8) @(posedge clk_sys);
            chk("fifo_count", fcnt[7:0], bad ? (s8 ? 8'h03 : 8'h04) : 8'h02);
            chk("fifo_last", flast, bad ? (s8 ? b2 : c[15:8]) : 8'h34);
            chk("crc_err", crc_error_flag, bad[0]);
            rdc("status_crc", rcc_pkg::IDX_STATUS, {7'h00, bad[0]});
            wr(rcc_pkg::IDX_STATUS, 8'h03);
         end
         if (m == 0) begin
            ev(4);
            chk("calc_preset", crc_result, 16'h6363);
         end
      end
      $display("test crc done");
      for (int m = 0; m < 2; m++) begin
         cv = m ? 8'h00 : 8'h03;
         wr(rcc_pkg::IDX_CHAN, cv);
         chk("tx_flags_off", {tx_crc_append, tx_parity_insert}, {1'b0, cv[0]});
         fcnt = 0;
         ev(2);
         xb(1'b1, 8'h01, 1'b1);
         ev(3);
         chk("par_err", parity_error_flag, cv[0]);
         chk("fifo_pass", {fcnt[7:0], flast}, 16'h0101);
         rdc("status_par", rcc_pkg::IDX_STATUS, {6'h00, cv[0], 1'b0});
         wr(rcc_pkg::IDX_STATUS, 8'h03);
      end
      $display("test parity done");
      close_out();
   end
endmodule
